/* File: hw/pcdc_pkg.sv */
package pcdc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] PCDC_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] PCDC_FREQ_OFFSET = 8'h04;

	// control register fields
	localparam int PCDC_LCD_SEL_LSB = 11;
	localparam int PCDC_SYS_SEL_LSB = 8;
	localparam int PCDC_FIRST_PRESCALER_SEL_BIT = 7;
	localparam int PCDC_SECOND_PRESCALER_SEL_BIT = 5;
	localparam int PCDC_CLKOUT_N_BIT = 4;
	localparam int PCDC_DISABLE_BIT = 3;
	localparam int PCDC_WAKE_SEL_LSB = 0;
	localparam logic [15:0] PCDC_CTRL_WMASK = 16'h3fbb;
	localparam logic [15:0] PCDC_CTRL_RESET = 16'h24b3;

	// frequency select register fields
	localparam int PCDC_REF_BIT = 15;
	localparam int PCDC_FREQ_WRITE_PROTECT_BIT = 14;
	localparam int PCDC_Q_LSB = 8;
	localparam int PCDC_P_LSB = 0;
	localparam logic [3:0] PCDC_Q_RESET = 4'h3;
	localparam logic [7:0] PCDC_P_RESET = 8'h47;
	localparam logic PCDC_FREQ_WRITE_PROTECT_RESET = 1'b0;

	// divide exponent of each divider stage after reset
	localparam logic [2:0] PCDC_EXP_DIV1 = 3'h0;
	localparam logic [2:0] PCDC_EXP_DIV2 = 3'h1;

	// shutdown delay in system clock cycles
	localparam logic [4:0] PCDC_SHUTDOWN_CYCLES = 5'h1e;

	// wake-up delays in reference clock periods
	localparam logic [6:0] PCDC_WAKE_32 = 7'h20;
	localparam logic [6:0] PCDC_WAKE_48 = 7'h30;
	localparam logic [6:0] PCDC_WAKE_64 = 7'h40;
	localparam logic [6:0] PCDC_WAKE_96 = 7'h60;

	// multiplier equation constants
	localparam logic [15:0] PCDC_MULT_STEP = 16'h000e;

	localparam logic [1:0] PCDC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] PCDC_HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0] {
		PCDC_RUN,
		PCDC_SHUTDOWN,
		PCDC_SLEEP,
		PCDC_WAKE
	} pcdc_state_t;

endpackage

/* File: hw/pcdc_divider.sv */
`timescale 1ns/1ps
`default_nettype none

// divides a tick stream by 2**exp; new exponent taken only at wrap
module pcdc_divider #(
	parameter logic [2:0] RESET_EXP = 3'h0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick_in,
	input wire logic [2:0] exp_sel,
	output logic tick_out
);

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [2:0] exp_reg;
	logic tick_reg;
	logic [3:0] last_count;
	logic at_wrap;

	always_comb begin
		unique case (exp_reg)
			3'h0: last_count = 4'h0;
			3'h1: last_count = 4'h1;
			3'h2: last_count = 4'h3;
			3'h3: last_count = 4'h7;
			3'h4: last_count = 4'hf;
			default: last_count = 4'h0;
		endcase
	end

	assign at_wrap = cnt_reg == last_count;
	assign cnt_next = at_wrap ? 4'h0 : 4'(cnt_reg + 4'h1);

	// ratio changes only at a period boundary, so no runt output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 4'h0;
			exp_reg <= RESET_EXP;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= tick_in && at_wrap;
			if (tick_in) begin
				cnt_reg <= cnt_next;
				if (at_wrap) begin
					exp_reg <= exp_sel;
				end
			end
		end
	end

	assign tick_out = tick_reg;

endmodule

`default_nettype wire

/* File: hw/pcdc_top.sv */
// Notes on behaviour
// - lcd select 13:11 divides dma clock by 2/4/8/16, 1xx by 1.
// - system select 10:8 divides dma clock, same encoding, resets 100.
// - bit 7 set halves the loop output, clear passes it; resets set.
// - bit 5 set halves first prescaler output into dma clock.
// - clock-out pin driven only when bit 4 and port select both clear.
// - loop disable bit 3 stops the loop and enters sleep.
// - wake delay 1:0 selects 32, 48, 64 or 96 reference periods.
// - wake delay counts reference clock periods, not system clocks.
// - frequency bit 15 reads the reference clock level.
// - protect bit 14 blocks later p/q writes; only reset clears it.
// - multiplier is 2*(14*(p+1)+q+1), 2024 by default.
// - loop keeps running 30 system clocks after disable is set.
// - wake event restarts loop; clocks resume after the wake delay.
`timescale 1ns/1ps
`default_nettype none

module pcdc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic low_freq_ref_clock,
	input wire logic port_function_select,
	input wire logic wake_event,
	output logic loop_enable,
	output logic [15:0] loop_multiplier,
	output logic loop_output_clock,
	output logic first_prescaler_clock,
	output logic dma_clock,
	output logic system_clock,
	output logic lcd_clock,
	output logic clock_out_port_pin_o,
	output logic clock_out_port_pin_oe,
	output logic sleep_active
);

	import pcdc_pkg::*;

	// bus slave state
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [1:0] wr_strb_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic hreadyout_reg;

	// software visible state
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [3:0] q_reg;
	logic [7:0] p_reg;
	logic freq_write_protect_reg;

	// reference clock synchroniser and filter
	logic ref_s1_reg;
	logic ref_s2_reg;
	logic ref_s3_reg;
	logic ref_level_reg;
	logic ref_rise;

	// sleep sequencing
	pcdc_state_t state_reg;
	pcdc_state_t state_next;
	logic [4:0] shut_cnt_reg;
	logic [6:0] wake_cnt_reg;
	logic [6:0] wake_target;

	// output flops
	logic [15:0] mult_reg;
	logic [15:0] mult_next;
	logic loop_tick_reg;
	logic loop_en_reg;
	logic pin_o_reg;
	logic pin_oe_reg;
	logic sleep_reg;

	// divider chain
	logic pr1_tick;
	logic dma_tick;
	logic sys_tick;
	logic lcd_tick;
	logic [2:0] lcd_exp;
	logic [2:0] sys_exp;
	logic [2:0] pr1_exp;
	logic [2:0] pr2_exp;

	// address phase decode
	wire addr_phase = hsel && hready && htrans[1];
	wire rd_req = addr_phase && !hwrite;
	wire wr_req = addr_phase && hwrite;
	wire ctrl_hit = wr_addr_reg == PCDC_CTRL_OFFSET;
	wire freq_hit = wr_addr_reg == PCDC_FREQ_OFFSET;
	wire ctrl_rd = haddr[7:0] == PCDC_CTRL_OFFSET;
	wire freq_rd = haddr[7:0] == PCDC_FREQ_OFFSET;
	wire upper_zero = haddr[31:8] == 24'h000000;
	wire size_word = hsize == 3'h2;
	wire size_half = hsize == 3'h1;
	wire size_byte = hsize == 3'h0;

	// low halfword lanes touched by this access
	wire [1:0] strb_req =
		size_word ? 2'h3 :
		(size_half && !haddr[1]) ? 2'h3 :
		(size_byte && haddr[1:0] == 2'h0) ? 2'h1 :
		(size_byte && haddr[1:0] == 2'h1) ? 2'h2 :
		2'h0;

	wire [15:0] lane_mask = {{8{wr_strb_reg[1]}}, {8{wr_strb_reg[0]}}};
	wire [15:0] wdata = hwdata[15:0];
	wire ctrl_wr = wr_pend_reg && ctrl_hit;
	wire freq_wr = wr_pend_reg && freq_hit;
	wire hi_lane = wr_strb_reg[1];
	wire lo_lane = wr_strb_reg[0];

	// control register field views
	wire [2:0] lcd_sel = ctrl_reg[PCDC_LCD_SEL_LSB +: 3];
	wire [2:0] sys_sel = ctrl_reg[PCDC_SYS_SEL_LSB +: 3];
	wire first_prescaler_sel_sel = ctrl_reg[PCDC_FIRST_PRESCALER_SEL_BIT];
	wire second_prescaler_sel_sel = ctrl_reg[PCDC_SECOND_PRESCALER_SEL_BIT];
	wire clock_out_enable_n = ctrl_reg[PCDC_CLKOUT_N_BIT];
	wire loop_disable = ctrl_reg[PCDC_DISABLE_BIT];
	wire [1:0] wake_delay_sel = ctrl_reg[PCDC_WAKE_SEL_LSB +: 2];

	// read values; reserved bits read zero
	wire [15:0] ctrl_rdata = ctrl_reg & PCDC_CTRL_WMASK;
	wire [15:0] freq_rdata = {ref_level_reg, freq_write_protect_reg, 2'h0,
		q_reg, p_reg};

	assign hrdata_next =
		!upper_zero ? 32'h00000000 :
		ctrl_rd ? {16'h0000, ctrl_rdata} :
		freq_rd ? {16'h0000, freq_rdata} :
		32'h00000000;

	// shared code for lcd and system selectors: 1xx means by 1
	function automatic logic [2:0] sel_to_exp(input logic [2:0] code);
		logic [2:0] e;
		e = PCDC_EXP_DIV1;
		if (!code[2]) begin
			e = 3'({1'b0, code[1:0]} + 3'h1);
		end
		return e;
	endfunction

	assign lcd_exp = sel_to_exp(lcd_sel);
	assign sys_exp = sel_to_exp(sys_sel);
	assign pr1_exp = {2'h0, first_prescaler_sel_sel};
	assign pr2_exp = {2'h0, second_prescaler_sel_sel};

	// bus address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_strb_reg <= 2'h0;
			hrdata_reg <= 32'h00000000;
			hreadyout_reg <= 1'b1;
		end else begin
			wr_pend_reg <= wr_req && upper_zero;
			if (wr_req) begin
				wr_addr_reg <= haddr[7:0] & 8'hfc;
				wr_strb_reg <= strb_req;
			end
			if (rd_req) begin
				hrdata_reg <= hrdata_next;
			end
			hreadyout_reg <= 1'b1;
		end
	end

	// control register: software write, hardware clears disable at wake
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr) begin
			ctrl_next = (ctrl_reg & ~(lane_mask & PCDC_CTRL_WMASK)) |
				(wdata & lane_mask & PCDC_CTRL_WMASK);
		end
		if (state_reg == PCDC_SLEEP && wake_event) begin
			ctrl_next[PCDC_DISABLE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= PCDC_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// frequency select register; protect is sticky until reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_reg <= PCDC_Q_RESET;
			p_reg <= PCDC_P_RESET;
			freq_write_protect_reg <= PCDC_FREQ_WRITE_PROTECT_RESET;
		end else if (freq_wr) begin
			if (hi_lane && wdata[PCDC_FREQ_WRITE_PROTECT_BIT]) begin
				freq_write_protect_reg <= 1'b1;
			end
			if (hi_lane && !freq_write_protect_reg) begin
				q_reg <= wdata[PCDC_Q_LSB +: 4];
			end
			if (lo_lane && !freq_write_protect_reg) begin
				p_reg <= wdata[PCDC_P_LSB +: 8];
			end
		end
	end

	// reference clock: three flops, accept a level once two agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
			ref_level_reg <= 1'b0;
		end else begin
			ref_s1_reg <= low_freq_ref_clock;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
			if (ref_s2_reg == ref_s3_reg) begin
				ref_level_reg <= ref_s3_reg;
			end
		end
	end

	assign ref_rise = ref_s2_reg && ref_s3_reg && !ref_level_reg;

	always_comb begin
		unique case (wake_delay_sel)
			2'h0: wake_target = PCDC_WAKE_32;
			2'h1: wake_target = PCDC_WAKE_48;
			2'h2: wake_target = PCDC_WAKE_64;
			2'h3: wake_target = PCDC_WAKE_96;
		endcase
	end

	wire shut_done = shut_cnt_reg == PCDC_SHUTDOWN_CYCLES;
	wire wake_done = wake_cnt_reg == wake_target;

	// sleep sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PCDC_RUN: begin
				if (loop_disable) begin
					state_next = PCDC_SHUTDOWN;
				end
			end
			PCDC_SHUTDOWN: begin
				if (shut_done) begin
					state_next = PCDC_SLEEP;
				end
			end
			PCDC_SLEEP: begin
				if (wake_event) begin
					state_next = PCDC_WAKE;
				end
			end
			PCDC_WAKE: begin
				if (wake_done) begin
					state_next = PCDC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= PCDC_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// shutdown counts system clock periods while the chain still runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shut_cnt_reg <= 5'h00;
		end else if (state_reg != PCDC_SHUTDOWN) begin
			shut_cnt_reg <= 5'h00;
		end else if (sys_tick && !shut_done) begin
			shut_cnt_reg <= 5'(shut_cnt_reg + 5'h01);
		end
	end

	// wake delay counts reference rising edges only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_cnt_reg <= 7'h00;
		end else if (state_reg != PCDC_WAKE) begin
			wake_cnt_reg <= 7'h00;
		end else if (ref_rise && !wake_done) begin
			wake_cnt_reg <= 7'(wake_cnt_reg + 7'h01);
		end
	end

	// loop multiplier seen by the analog loop
	assign mult_next = 16'(((16'({8'h00, p_reg}) + 16'h0001) *
		PCDC_MULT_STEP + 16'({12'h000, q_reg}) + 16'h0001) << 1);

	wire loop_out_on = state_next == PCDC_RUN ||
		state_next == PCDC_SHUTDOWN;
	wire loop_powered = state_next != PCDC_SLEEP;

	// pin drive: buffered system clock, gated by both enables
	wire pin_oe_next = !clock_out_enable_n && !port_function_select;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mult_reg <= 16'h0000;
			loop_tick_reg <= 1'b0;
			loop_en_reg <= 1'b0;
			pin_o_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
			sleep_reg <= 1'b0;
		end else begin
			mult_reg <= mult_next;
			loop_tick_reg <= loop_out_on;
			loop_en_reg <= loop_powered;
			pin_o_reg <= pin_oe_next && sys_tick;
			pin_oe_reg <= pin_oe_next;
			sleep_reg <= state_next == PCDC_SLEEP;
		end
	end

	// cascaded divider chain, one tick stream per derived clock
	pcdc_divider #(
		.RESET_EXP(PCDC_EXP_DIV2)
	) u_first_prescaler_sel (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_in(loop_tick_reg),
		.exp_sel(pr1_exp),
		.tick_out(pr1_tick)
	);

	pcdc_divider #(
		.RESET_EXP(PCDC_EXP_DIV2)
	) u_second_prescaler_sel (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_in(pr1_tick),
		.exp_sel(pr2_exp),
		.tick_out(dma_tick)
	);

	pcdc_divider #(
		.RESET_EXP(PCDC_EXP_DIV1)
	) u_sys_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_in(dma_tick),
		.exp_sel(sys_exp),
		.tick_out(sys_tick)
	);

	pcdc_divider #(
		.RESET_EXP(PCDC_EXP_DIV1)
	) u_lcd_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_in(dma_tick),
		.exp_sel(lcd_exp),
		.tick_out(lcd_tick)
	);

	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign loop_enable = loop_en_reg;
	assign loop_multiplier = mult_reg;
	assign loop_output_clock = loop_tick_reg;
	assign first_prescaler_clock = pr1_tick;
	assign dma_clock = dma_tick;
	assign system_clock = sys_tick;
	assign lcd_clock = lcd_tick;
	assign clock_out_port_pin_o = pin_o_reg;
	assign clock_out_port_pin_oe = pin_oe_reg;
	assign sleep_active = sleep_reg;

endmodule

`default_nettype wire

/* File: testbench/pcdc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pcdc_checker
	import pcdc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic low_freq_ref_clock,
	input wire logic port_function_select,
	input wire logic wake_event,
	input wire logic loop_enable,
	input wire logic [15:0] loop_multiplier,
	input wire logic loop_output_clock,
	input wire logic first_prescaler_clock,
	input wire logic dma_clock,
	input wire logic system_clock,
	input wire logic clock_out_port_pin_o,
	input wire logic clock_out_port_pin_oe,
	input wire logic sleep_active
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wr_ctrl_reg, wr_freq_reg, freq_write_protect_reg, waking_reg, ref_reg;
	logic [7:0] p_reg, rises_reg;
	logic [3:0] q_reg;
	logic [5:0] sd_reg;
	logic sd_arm_reg;
	wire logic take = hsel && hready && htrans[1] && hwrite;
	wire logic sd_start = wr_ctrl_reg && hwdata[PCDC_DISABLE_BIT];
	wire logic wake_now = sleep_active && wake_event;
	wire logic ref_rise = waking_reg && low_freq_ref_clock && !ref_reg;
	wire logic [15:0] mult_exp = 16'(2 * (14 * (p_reg + 1) + q_reg + 1));
	// shadow of word writes only; byte lanes are not modelled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_ctrl_reg, wr_freq_reg, waking_reg, ref_reg} <= 4'h0;
			freq_write_protect_reg <= PCDC_FREQ_WRITE_PROTECT_RESET;
			p_reg <= PCDC_P_RESET;
			q_reg <= PCDC_Q_RESET;
			rises_reg <= 8'h00;
			sd_reg <= 6'h00;
			sd_arm_reg <= 1'b0;
		end else begin
			wr_ctrl_reg <= take && haddr[7:0] == PCDC_CTRL_OFFSET;
			wr_freq_reg <= take && haddr[7:0] == PCDC_FREQ_OFFSET;
			if (wr_freq_reg && !freq_write_protect_reg) begin
				p_reg <= hwdata[7:0];
				q_reg <= hwdata[11:8];
			end
			freq_write_protect_reg <= freq_write_protect_reg || (wr_freq_reg && hwdata[PCDC_FREQ_WRITE_PROTECT_BIT]);
			ref_reg <= low_freq_ref_clock;
			waking_reg <= wake_now || (waking_reg && !loop_output_clock);
			rises_reg <= wake_now ? 8'h00 : rises_reg + 8'(ref_rise);
			// shutdown counting starts two edges after the write lands
			sd_arm_reg <= sd_start;
			sd_reg <= (sd_start || sd_arm_reg) ? 6'h00 :
				sd_reg + 6'(system_clock);
		end
	end
	sequence wake_s;
		sleep_active && wake_event;
	endsequence
	sequence freq_wr_s;
		wr_freq_reg;
	endsequence
	sleep_quiet_a: assert property (
		sleep_active && $past(sleep_active) |-> !loop_enable && !loop_output_clock)
		else $error("loop running in sleep");
	wake_start_a: assert property (wake_s |=> loop_enable && !sleep_active)
		else $error("wake did not restart loop");
	// one pin rise may sit in the synchroniser at wake time
	wake_early_a: assert property (
		waking_reg && loop_output_clock |-> rises_reg >= 8'd31)
		else $error("loop resumed too early");
	wake_late_a: assert property (waking_reg |-> rises_reg <= 8'd97)
		else $error("loop resumed too late");
	shutdown_len_a: assert property ($rose(sleep_active) |-> sd_reg == 6'd30)
		else $error("shutdown length wrong");
	pin_port_a: assert property (
		clock_out_port_pin_oe |-> !$past(port_function_select))
		else $error("pin driven while port selected");
	pin_drive_a: assert property (
		clock_out_port_pin_o |-> clock_out_port_pin_oe)
		else $error("pin toggles while disabled");
	dma_src_a: assert property (
		dma_clock |-> first_prescaler_clock || $past(first_prescaler_clock))
		else $error("dma tick without prescaler tick");
	mult_val_a: assert property (
		freq_wr_s |=> ##[0:2] loop_multiplier == mult_exp)
		else $error("multiplier mismatch");
endmodule
bind pcdc_top pcdc_checker pcdc_checker_i (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .low_freq_ref_clock,
	.port_function_select, .wake_event, .loop_enable, .loop_multiplier,
	.loop_output_clock, .first_prescaler_clock, .dma_clock, .system_clock,
	.clock_out_port_pin_o, .clock_out_port_pin_oe, .sleep_active);
`default_nettype wire

/* File: testbench/pcdc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pcdc_top_tb_top;
	import pcdc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic low_freq_ref_clock = 1'b0;
	logic port_function_select = 1'b0;
	logic wake_event = 1'b0;
	logic rd_valid = 1'b0;
	logic [2:0] ref_div = 3'h0;
	logic hreadyout, hresp, loop_enable, loop_output_clock, lcd_clock;
	logic first_prescaler_clock, dma_clock, system_clock, sleep_active;
	logic clock_out_port_pin_o, clock_out_port_pin_oe;
	logic [31:0] hrdata;
	logic [15:0] loop_multiplier;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int bad_count = 0;
	int n_checks = 0;
	int seed = 92216;
	int cnt[6];
	pcdc_top pcdc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.low_freq_ref_clock, .port_function_select, .wake_event,
		.loop_enable, .loop_multiplier, .loop_output_clock,
		.first_prescaler_clock, .dma_clock, .system_clock, .lcd_clock,
		.clock_out_port_pin_o, .clock_out_port_pin_oe, .sleep_active);
	always #5 hclk = ~hclk;
	// reference period of 16 hclk keeps wake waits short
	always @(posedge hclk) begin
		ref_div <= ref_div + 3'h1;
		if (ref_div == 3'h7)
			low_freq_ref_clock <= ~low_freq_ref_clock;
	end
	// read data taken at the edge that ends the data phase
	always @(posedge hclk) begin
		if (rd_valid) begin
			check(hrdata & msk_q.pop_front(), exp_q.pop_front());
			check({30'h0, hreadyout, hresp}, 32'h2);
		end
	end
	// tick counts sampled mid-cycle, clear of the launching edge
	always @(negedge hclk) begin
		cnt[0] += loop_output_clock;
		cnt[1] += first_prescaler_clock;
		cnt[2] += dma_clock;
		cnt[3] += system_clock;
		cnt[4] += lcd_clock;
		cnt[5] += clock_out_port_pin_o;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [15:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= PCDC_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {16'h0, d};
		rd_valid <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_valid <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e,
		input logic [15:0] m);
		exp_q.push_back({16'h0, e & m});
		msk_q.push_back({16'h0, m});
		bus(a, 1'b0, 16'h0);
	endtask
	task automatic measure(input int n);
		cnt = '{6{0}};
		repeat (n) @(posedge hclk);
	endtask
	function automatic int per(input logic [2:0] c);
		return c[2] ? 1 : 2 << c[1:0];
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		bad_count++;
		give_verdict();
	end
	initial begin
		logic [31:0] r;
		logic [15:0] cv;
		int dp, t, n;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(PCDC_CTRL_OFFSET, PCDC_CTRL_RESET, 16'hffff);
		rd(PCDC_FREQ_OFFSET, 16'h0347, 16'h7fff);
		rd(8'h08, 16'h0000, 16'hffff);
		check(loop_multiplier, 32'd2024);
		bus(PCDC_CTRL_OFFSET, 1'b1, 16'hfff7);
		rd(PCDC_CTRL_OFFSET, 16'h3fb3, 16'hffff);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			port_function_select <= r[12];
			cv = {2'h0, r[7:2], r[1], 1'b0, r[0], r[8], 4'h3};
			bus(PCDC_CTRL_OFFSET, 1'b1, cv);
			rd(PCDC_CTRL_OFFSET, cv, 16'hffff);
			// old ratio may run one long period before the switch
			repeat (80) @(posedge hclk);
			measure(256);
			dp = (1 + r[1]) * (1 + r[0]);
			check(cnt[0], 256);
			check(cnt[1], 256 >> r[1]);
			check(cnt[2], 256 / dp);
			check(cnt[3], 256 / (dp * per(r[4:2])));
			check(cnt[4], 256 / (dp * per(r[7:5])));
			check(cnt[5], (r[8] | r[12]) ? 0 : 256 / (dp * per(r[4:2])));
			@(negedge hclk);
			check(clock_out_port_pin_oe, !(r[8] | r[12]));
			@(posedge hclk);
		end
		@(posedge low_freq_ref_clock);
		repeat (5) @(posedge hclk);
		rd(PCDC_FREQ_OFFSET, 16'h8000, 16'h8000);
		@(negedge low_freq_ref_clock);
		repeat (5) @(posedge hclk);
		rd(PCDC_FREQ_OFFSET, 16'h0000, 16'h8000);
		bus(PCDC_FREQ_OFFSET, 1'b1, 16'h041b);
		rd(PCDC_FREQ_OFFSET, 16'h041b, 16'h7fff);
		repeat (3) @(posedge hclk);
		check(loop_multiplier, 32'd794);
		bus(PCDC_FREQ_OFFSET, 1'b1, 16'h4520);
		bus(PCDC_FREQ_OFFSET, 1'b1, 16'h0347);
		rd(PCDC_FREQ_OFFSET, 16'h4520, 16'h7fff);
		repeat (3) @(posedge hclk);
		check(loop_multiplier, 32'd936);
		// only a reset may lift the write protection
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(PCDC_FREQ_OFFSET, 16'h0347, 16'h7fff);
		check(loop_multiplier, 32'd2024);
		bus(PCDC_FREQ_OFFSET, 1'b1, 16'h0520);
		rd(PCDC_FREQ_OFFSET, 16'h0520, 16'h7fff);
		for (int k = 0; k < 4; k++) begin
			cv = 16'h24b0 | 16'(k);
			bus(PCDC_CTRL_OFFSET, 1'b1, cv | 16'h0008);
			t = 0;
			while (sleep_active !== 1'b1 && t < 400) begin
				@(negedge hclk);
				t++;
			end
			check(sleep_active, 1'b1);
			repeat (8) @(posedge hclk);
			measure(64);
			check(cnt[2], 0);
			check(loop_enable, 1'b0);
			wake_event <= 1'b1;
			@(posedge hclk);
			wake_event <= 1'b0;
			n = (k == 3) ? 96 : 32 + 16 * k;
			t = 0;
			while (loop_output_clock !== 1'b1 && t < 3000) begin
				@(negedge hclk);
				t++;
			end
			check(t > (n - 1) * 16 && t < (n + 1) * 16 + 8, 1'b1);
			@(posedge hclk);
			rd(PCDC_CTRL_OFFSET, cv, 16'hffff);
		end
		repeat (4) @(posedge hclk);
		give_verdict();
	end
endmodule
`default_nettype wire
